// ==== hdl/pmrc_ctrl.sv ====
`timescale 1ns/1ps
// Behaviour
// - idle bit halts cpu after the setting instruction; clocks and peripherals keep running
// - an enabled interrupt in idle clears idle and resumes the cpu
// - reset during idle runs the normal reset sequence from address zero
// - stop bit stops oscillator, cpu and peripherals after the setting instruction
// - interrupts are ignored in stop; other clock enables keep their state
// - only a reset leaves stop, then normal reset sequence from address zero
// - stop and idle bits always read as zero
// - upper six power control bits are plain software flags
// - reset halts execution, resets registers, forces ports, disables interrupts
// - reset leaves data memory intact; the stack pointer is reset with the other registers
// - reset loads port latches with ones, open drain, pullups kept on
// - power-on and supply resets drive the reset pin low while in reset
// - reset exit clears program counter and selects the internal oscillator
// - power-up holds reset until supply is good, then a power-on delay
// - power-on and supply reset exits set the power-on flag; other resets clear it
// - writing one to the pin flag forces a power-on reset
// - supply below threshold holds reset with pin low until it recovers
// - supply monitor enabled by power-on reset, kept across other resets
// - suspended oscillator stays stopped until usb activity, vbus match or a reset
// - lost clock timeout resets the device without touching the reset pin

module pmrc_ctrl
   import pmrc_pkg::*;
#(
   parameter int POR_DELAY = POR_DELAY_CYCLES
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_we,
   output logic [7:0] sfr_rdata,
   input wire logic instr_done,
   input wire logic irq_wake,
   input wire logic vdd_ok,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire logic lost_clock_timeout,
   input wire logic flash_error,
   input wire logic usb_reset_seen,
   input wire logic usb_nonidle_event,
   input wire logic vbus_level,
   input wire logic bus_power_polarity,
   input wire logic osc_suspend_req,
   output logic sys_reset,
   output logic cpu_halt,
   output logic osc_stop,
   output logic periph_stop,
   output logic irq_ignore,
   output logic reset_exit,
   output logic port_force,
   output logic [7:0] port_latch_value,
   output logic weak_pullup_en
);

   localparam int CNT_W = $clog2(POR_DELAY + 1);
   // refused at elaboration: the delay state needs a cycle to leave from
   if (POR_DELAY < 1) begin : g_bad_delay
      $error("POR_DELAY must be at least one cycle");
   end

   ////////////////////////////////////////////////////////////////////////////////

   pmrc_state_t st, next_state;
   pmrc_cause_t cause, next_cause;
   logic [CNT_W-1:0] por_cnt;
   logic [5:0] software_flags;
   logic [7:0] cause_flags;
   logic idle_pend, stop_pend, supply_en, supply_sel;
   logic lost_clock_en, usb_rst_en, osc_susp, next_osc_susp;
   logic live, pmc_wr, rcr_wr, smc_wr, force_por, soft_rst, supply_rst, pin_rst;
   logic lcd_rst, usb_rst, rst_any, idle_go, stop_go, hold, in_reset_next;
   // writes only land outside reset, in run, idle or stop
   assign live = (st == S_RUN) || (st == S_IDLE) || (st == S_STOP);
   assign pmc_wr = live && sfr_we && (sfr_addr == PMC_ADDR);
   assign rcr_wr = live && sfr_we && (sfr_addr == RCR_ADDR);
   assign smc_wr = live && sfr_we && (sfr_addr == SMC_ADDR);
   assign force_por = rcr_wr && sfr_wdata[RCR_PIN_BIT];
   assign soft_rst = rcr_wr && sfr_wdata[RCR_SOFT_BIT];
   // selecting a monitor that is not on trips it at once
   assign supply_rst = (supply_sel && supply_en && !vdd_ok)
      || (rcr_wr && sfr_wdata[RCR_POR_BIT] && !supply_en);
   // our own drive of the pin must not look like an external reset
   assign pin_rst = !rst_pin_in && !rst_pin_oe;
   assign lcd_rst = lost_clock_en && lost_clock_timeout;
   assign usb_rst = usb_rst_en && (usb_reset_seen || (vbus_level == bus_power_polarity));
   assign rst_any = live && (force_por || supply_rst || pin_rst || lcd_rst || flash_error
      || soft_rst || usb_rst);
   // stop wins when both bits arrive together
   assign stop_go = stop_pend || (pmc_wr && sfr_wdata[PMC_STOP_BIT]);
   assign idle_go = idle_pend || (pmc_wr && sfr_wdata[PMC_IDLE_BIT]);
   assign hold = ((cause == C_SUPPLY) && !vdd_ok) || pin_rst;

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      next_cause = cause;
      if (rst_any) begin
         if (force_por) begin
            next_cause = C_POR;
         end else if (supply_rst) begin
            next_cause = C_SUPPLY;
         end else if (pin_rst) begin
            next_cause = C_PIN;
         end else if (lcd_rst) begin
            next_cause = C_LOST_CLK;
         end else if (flash_error) begin
            next_cause = C_FLASH;
         end else if (soft_rst) begin
            next_cause = C_SOFT;
         end else begin
            next_cause = C_USB;
         end
      end
   end

   always_comb begin
      next_state = st;
      if (rst_any) begin
         next_state = force_por ? S_POR_HOLD : S_RESET;
      end else begin
         unique case (st)
            S_POR_HOLD: begin
               if (vdd_ok) begin
                  next_state = S_POR_DELAY;
               end
            end
            S_POR_DELAY: begin
               if (!vdd_ok) begin
                  next_state = S_POR_HOLD;
               end else if (por_cnt == CNT_W'(POR_DELAY - 1)) begin
                  next_state = S_RUN;
               end
            end
            S_RUN: begin
               if (instr_done && stop_go) begin
                  next_state = S_STOP;
               end else if (instr_done && idle_go) begin
                  next_state = S_IDLE;
               end
            end
            S_IDLE: begin
               if (irq_wake) begin
                  next_state = S_RUN;
               end
            end
            S_STOP: begin
               next_state = S_STOP;
            end
            S_RESET: begin
               if (!hold) begin
                  next_state = S_RUN;
               end
            end
            default: begin
               next_state = S_POR_HOLD;
            end
         endcase
      end
   end

   assign in_reset_next = (next_state == S_POR_HOLD) || (next_state == S_POR_DELAY)
      || (next_state == S_RESET);
   always_ff @(posedge clock) begin
      if (srst) begin
         st <= S_POR_HOLD;
         cause <= C_POR;
      end else begin
         st <= next_state;
         cause <= (next_state == S_POR_HOLD) ? C_POR : next_cause;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || (st != S_POR_DELAY)) begin
         por_cnt <= '0;
      end else begin
         por_cnt <= por_cnt + CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers; every reset reloads them except supply_en, data memory is never touched here

   always_ff @(posedge clock) begin
      if (srst || in_reset_next) begin
         software_flags <= PMC_FLAGS_RESET;
         idle_pend <= 1'b0;
         stop_pend <= 1'b0;
      end else begin
         if (pmc_wr) begin
            software_flags <= sfr_wdata[7:PMC_FLAG_LSB];
         end
         // entering idle clears the pending idle select bit, before any wake
         idle_pend <= (next_state == S_RUN) && idle_go && !instr_done;
         stop_pend <= (next_state == S_RUN) && stop_go && !instr_done;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         supply_en <= 1'b1;
      end else if (force_por && rst_any) begin
         supply_en <= 1'b1;
      end else if (smc_wr && !rst_any) begin
         supply_en <= sfr_wdata[SMC_EN_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (srst || in_reset_next) begin
         supply_sel <= 1'b0;
         lost_clock_en <= 1'b0;
         usb_rst_en <= 1'b0;
      end else if (rcr_wr) begin
         supply_sel <= sfr_wdata[RCR_POR_BIT];
         lost_clock_en <= sfr_wdata[RCR_LCD_BIT];
         usb_rst_en <= sfr_wdata[RCR_USB_BIT];
      end
   end

   // flags change only on the way out of reset
   always_ff @(posedge clock) begin
      if (srst) begin
         cause_flags <= RCR_FLAGS_RESET;
      end else if ((st != next_state) && (next_state == S_RUN) && !live) begin
         cause_flags <= '0;
         cause_flags[RCR_POR_BIT] <= (cause == C_POR) || (cause == C_SUPPLY);
         cause_flags[RCR_PIN_BIT] <= (cause == C_PIN);
         cause_flags[RCR_LCD_BIT] <= (cause == C_LOST_CLK);
         cause_flags[RCR_FLASH_BIT] <= (cause == C_FLASH);
         cause_flags[RCR_SOFT_BIT] <= (cause == C_SOFT);
         cause_flags[RCR_USB_BIT] <= (cause == C_USB);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         sfr_rdata <= 8'h00;
      end else begin
         unique case (sfr_addr)
            PMC_ADDR: sfr_rdata <= {software_flags, 2'b00};
            RCR_ADDR: sfr_rdata <= cause_flags;
            SMC_ADDR: sfr_rdata <= {supply_en, vdd_ok, 6'h00};
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // oscillator suspend; a new request beats a wake in the same cycle

   always_comb begin
      next_osc_susp = osc_susp;
      if (in_reset_next) begin
         next_osc_susp = 1'b0;
      end else if (osc_suspend_req) begin
         next_osc_susp = 1'b1;
      end else if (usb_nonidle_event || (vbus_level == bus_power_polarity)) begin
         next_osc_susp = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         osc_susp <= 1'b0;
      end else begin
         osc_susp <= next_osc_susp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, registered from the next state so they change with it

   always_ff @(posedge clock) begin
      if (srst) begin
         sys_reset <= 1'b1;
         cpu_halt <= 1'b1;
         osc_stop <= 1'b0;
         periph_stop <= 1'b0;
         irq_ignore <= 1'b1;
         reset_exit <= 1'b0;
         port_force <= 1'b1;
         rst_pin_oe <= 1'b1;
      end else begin
         sys_reset <= in_reset_next;
         cpu_halt <= (next_state != S_RUN);
         osc_stop <= (next_state == S_STOP) || next_osc_susp;
         periph_stop <= (next_state == S_STOP);
         irq_ignore <= in_reset_next || (next_state == S_STOP);
         reset_exit <= !live && (st != next_state) && (next_state == S_RUN);
         port_force <= in_reset_next;
         rst_pin_oe <= (next_state == S_POR_HOLD) || (next_state == S_POR_DELAY)
            || ((next_state == S_RESET) && (next_cause == C_SUPPLY));
      end
   end

   // pin is open drain, only ever pulled low; latches and pullups are fixed
   always_ff @(posedge clock) begin
      rst_pin_out <= 1'b0;
      port_latch_value <= PORT_LATCH_RESET;
      weak_pullup_en <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   AST_IDLE_ENTRY: assert property (
      (st == S_RUN && idle_go && !stop_go && instr_done && !rst_any)
      |=> (st == S_IDLE && cpu_halt && !periph_stop && !irq_ignore))
      else $error("idle entry wrong");
   AST_IDLE_WAKE: assert property (
      (st == S_IDLE && irq_wake && !rst_any) |=> (st == S_RUN && !cpu_halt))
      else $error("idle wake wrong");
   AST_STOP_ENTRY: assert property (
      (st == S_RUN && stop_go && instr_done && !rst_any)
      |=> (st == S_STOP && osc_stop && periph_stop && cpu_halt))
      else $error("stop entry wrong");
   AST_STOP_IGNORES_IRQ: assert property (
      (st == S_STOP && !rst_any) |=> (st == S_STOP && irq_ignore))
      else $error("stop left without reset");
   AST_STOP_RESET_EXIT: assert property (
      (st == S_STOP && rst_any && !force_por) |=> (st == S_RESET && sys_reset))
      else $error("reset did not end stop");
   AST_SELECT_BITS_ZERO: assert property (
      (sfr_addr == PMC_ADDR) |=> (sfr_rdata[1:0] == 2'b00))
      else $error("select bits read nonzero");
   AST_FLAGS_READBACK: assert property (
      (pmc_wr && !rst_any) ##1 (sfr_addr == PMC_ADDR && !in_reset_next)
      |=> (sfr_rdata[7:2] == $past(sfr_wdata[7:2], 2)))
      else $error("software flags lost");
   AST_POR_PIN_LOW: assert property (
      (st == S_POR_HOLD || st == S_POR_DELAY) |-> (rst_pin_oe && !rst_pin_out && sys_reset))
      else $error("pin not driven in power-on reset");
   AST_POR_DELAY: assert property (
      (st == S_POR_HOLD && vdd_ok) ##1 (vdd_ok && !rst_any) [*2]
      |-> (st == S_POR_DELAY && sys_reset))
      else $error("power-on delay skipped");
   AST_POR_FLAG: assert property (
      (st == S_POR_DELAY && next_state == S_RUN)
      |=> (cause_flags[RCR_POR_BIT] && reset_exit) ##1 !reset_exit)
      else $error("power-on flag or exit pulse wrong");
   AST_FORCED_POR: assert property (
      force_por |=> (st == S_POR_HOLD && rst_pin_oe && supply_en))
      else $error("forced power-on reset missing");
   AST_SUPPLY_HOLD: assert property (
      (st == S_RESET && cause == C_SUPPLY && !vdd_ok) |=> (st == S_RESET && rst_pin_oe))
      else $error("supply reset released early");
   AST_MONITOR_KEPT: assert property (
      (rst_any && !force_por) |=> (supply_en == $past(supply_en)))
      else $error("monitor enable changed by reset");
   AST_LOST_CLK_PIN: assert property (
      (lcd_rst && !force_por && !supply_rst && !pin_rst) |=> (sys_reset && !rst_pin_oe))
      else $error("lost clock reset wrong");
   AST_SUSPEND_HOLDS: assert property (
      (osc_susp && !usb_nonidle_event && vbus_level != bus_power_polarity && !in_reset_next)
      |=> (osc_susp && osc_stop))
      else $error("oscillator woke without cause");

endmodule

// ==== hdl/pmrc_pkg.sv ====
package pmrc_pkg;

   // register addresses on the special-register port
   localparam logic [7:0] PMC_ADDR = 8'h87;
   localparam logic [7:0] RCR_ADDR = 8'hef;
   localparam logic [7:0] SMC_ADDR = 8'hff;

   // power_mode_control fields
   localparam int PMC_IDLE_BIT = 0;
   localparam int PMC_STOP_BIT = 1;
   localparam int PMC_FLAG_LSB = 2;
   localparam logic [5:0] PMC_FLAGS_RESET = 6'h00;

   // reset_cause_register fields
   localparam int RCR_PIN_BIT = 0;
   localparam int RCR_POR_BIT = 1;
   localparam int RCR_LCD_BIT = 2;
   localparam int RCR_SOFT_BIT = 4;
   localparam int RCR_FLASH_BIT = 6;
   localparam int RCR_USB_BIT = 7;
   localparam logic [7:0] RCR_FLAGS_RESET = 8'h02;

   // supply_monitor_control fields
   localparam int SMC_EN_BIT = 7;
   localparam int SMC_STAT_BIT = 6;

   // port state forced while in reset
   localparam logic [7:0] PORT_LATCH_RESET = 8'hff;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_DELAY_NS = 300000;
   localparam int POR_DELAY_MIN_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
   localparam int POR_DELAY_CYCLES = (POR_DELAY_MIN_CYC < 1) ? 1 : POR_DELAY_MIN_CYC;

   typedef enum logic [2:0] {
      S_POR_HOLD  = 3'h0,
      S_POR_DELAY = 3'h1,
      S_RUN       = 3'h3,
      S_IDLE      = 3'h2,
      S_STOP      = 3'h7,
      S_RESET     = 3'h6
   } pmrc_state_t;

   typedef enum logic [2:0] {
      C_POR      = 3'h0,
      C_SUPPLY   = 3'h1,
      C_PIN      = 3'h2,
      C_LOST_CLK = 3'h3,
      C_FLASH    = 3'h4,
      C_SOFT     = 3'h5,
      C_USB      = 3'h6
   } pmrc_cause_t;

endpackage

// ==== test/pmrc_partner.sv ====
`timescale 1ns/1ps
// cpu core and external reset circuit as seen from the block
module pmrc_partner (
   input wire logic clock,
   input wire logic slow,
   input wire logic press,
   input wire logic cpu_halt,
   input wire logic sys_reset,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   output logic instr_done,
   output logic rst_pin_in
);
   logic [1:0] cnt = 2'h0;
   // the pin has a pull-up, so released and unpressed reads high
   assign rst_pin_in = rst_pin_oe ? rst_pin_out : !press;
   // slow cpu finishes an instruction every third cycle only
   always @(negedge clock) begin
      cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      instr_done <= !cpu_halt && !sys_reset && (!slow || cnt == 2'h0);
   end
endmodule

// ==== test/power_mode_and_reset_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module power_mode_and_reset_control_tb;
   import pmrc_pkg::*;
   localparam int POR_SIM = 8;
   localparam logic [7:0] EN [6] = '{8'h00, 8'h04, 8'h00, 8'h10, 8'h80, 8'h02};
   localparam logic [7:0] FLG [6] = '{8'h01, 8'h04, 8'h40, 8'h10, 8'h80, 8'h02};
   logic clock, srst, sfr_we, instr_done, irq_wake, vdd_ok, rst_pin_in, rst_pin_out;
   logic rst_pin_oe, lost_clock_timeout, flash_error, usb_reset_seen, usb_nonidle_event;
   logic vbus_level, bus_power_polarity, osc_suspend_req, sys_reset, cpu_halt, osc_stop;
   logic periph_stop, irq_ignore, reset_exit, port_force, weak_pullup_en, press, slow;
   logic rd_tag, rd_q;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port_latch_value, exp_v;
   logic [7:0] expq[$];
   int errors = 0;
   int checks_done = 0;

   pmrc_ctrl #(.POR_DELAY(POR_SIM)) DUT (
      .clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_we(sfr_we), .sfr_rdata(sfr_rdata), .instr_done(instr_done),
      .irq_wake(irq_wake), .vdd_ok(vdd_ok), .rst_pin_in(rst_pin_in),
      .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .lost_clock_timeout(lost_clock_timeout), .flash_error(flash_error),
      .usb_reset_seen(usb_reset_seen), .usb_nonidle_event(usb_nonidle_event),
      .vbus_level(vbus_level), .bus_power_polarity(bus_power_polarity),
      .osc_suspend_req(osc_suspend_req), .sys_reset(sys_reset), .cpu_halt(cpu_halt),
      .osc_stop(osc_stop), .periph_stop(periph_stop), .irq_ignore(irq_ignore),
      .reset_exit(reset_exit), .port_force(port_force),
      .port_latch_value(port_latch_value), .weak_pullup_en(weak_pullup_en)
   );

   pmrc_partner cpu (
      .clock(clock), .slow(slow), .press(press), .cpu_halt(cpu_halt),
      .sys_reset(sys_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .instr_done(instr_done), .rst_pin_in(rst_pin_in)
   );

   initial clock = 1'b0;
   always #5 clock = ~clock;

   //////////////////////////////
   // read data lags the address by one edge, so the monitor looks one edge later
   always @(posedge clock) rd_q <= rd_tag;
   always @(negedge clock) begin
      if (rd_q) begin
         exp_v = expq.pop_front();
         `CHK(sfr_rdata, exp_v)
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_we = 1'b1;
      @(negedge clock);
      sfr_we = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      sfr_addr = a;
      expq.push_back(e);
      rd_tag = 1'b1;
      @(negedge clock);
      rd_tag = 1'b0;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return cpu_halt;
         1: return sys_reset;
         2: return reset_exit;
         default: return osc_stop;
      endcase
   endfunction

   task automatic wait_on(input int s, input logic v, input int lim, output int n);
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
   endtask

   task automatic cause(input int k, input logic [7:0] smc);
      int n;
      if (k != 3) wr(RCR_ADDR, EN[k]);
      if (k < 2) begin
         wr(PMC_ADDR, k ? 8'h03 : 8'h01);
         wait_on(0, 1'b1, 8, n);
         `CHK(osc_stop, k[0])
         `CHK(periph_stop, k[0])
         if (k == 1) begin
            irq_wake = 1'b1;
            repeat (4) @(negedge clock);
            `CHK(cpu_halt, 1'b1)
            irq_wake = 1'b0;
         end
      end
      @(negedge clock);
      case (k)
         0: press = 1'b1;
         1: lost_clock_timeout = 1'b1;
         2: flash_error = 1'b1;
         3: begin
            sfr_addr = RCR_ADDR;
            sfr_wdata = 8'h10;
            sfr_we = 1'b1;
         end
         4: usb_reset_seen = 1'b1;
         default: vdd_ok = 1'b0;
      endcase
      @(negedge clock);
      {lost_clock_timeout, flash_error, usb_reset_seen, sfr_we} = 4'h0;
      wait_on(1, 1'b1, 4, n);
      `CHK(sys_reset, 1'b1)
      `CHK(rst_pin_oe, k == 5)
      `CHK(port_force, 1'b1)
      if (k == 0 || k == 5) begin
         repeat (3) @(negedge clock);
         `CHK(sys_reset, 1'b1)
      end
      press = 1'b0;
      vdd_ok = 1'b1;
      wait_on(2, 1'b1, 10, n);
      `CHK(reset_exit, 1'b1)
      `CHK(cpu_halt, 1'b0)
      rd(RCR_ADDR, FLG[k]);
      rd(SMC_ADDR, smc);
   endtask

   //////////////////////////////
   initial begin
      #200000;
      errors++;
      finish_test();
   end

   initial begin
      int n;
      logic [7:0] f;
      void'($urandom(72));
      {sfr_addr, sfr_wdata, sfr_we, irq_wake, vdd_ok, lost_clock_timeout} = '0;
      {flash_error, usb_reset_seen, usb_nonidle_event, vbus_level} = '0;
      {osc_suspend_req, press, slow, rd_tag} = '0;
      bus_power_polarity = 1'b1;
      srst = 1'b1;
      repeat (5) @(negedge clock);
      srst = 1'b0;
      wr(PMC_ADDR, 8'hfc);
      repeat (3) @(negedge clock);
      `CHK(sys_reset, 1'b1)
      `CHK(irq_ignore, 1'b1)
      `CHK(rst_pin_oe, 1'b1)
      `CHK(rst_pin_out, 1'b0)
      `CHK(port_latch_value, PORT_LATCH_RESET)
      `CHK(weak_pullup_en, 1'b1)
      vdd_ok = 1'b1;
      wait_on(2, 1'b1, POR_SIM + 10, n);
      `CHK(reset_exit, 1'b1)
      `CHK(n >= POR_SIM, 1'b1)
      rd(RCR_ADDR, 8'h02);
      rd(SMC_ADDR, 8'hc0);
      rd(PMC_ADDR, 8'h00);
      rd(8'h10, 8'h00);
      for (int i = 0; i < 2; i++) begin
         slow = i[0];
         f = 8'($urandom) & 8'hfc;
         wr(PMC_ADDR, f | 8'h01);
         wait_on(0, 1'b1, 8, n);
         `CHK(cpu_halt, 1'b1)
         `CHK(osc_stop | periph_stop | irq_ignore, 1'b0)
         rd(PMC_ADDR, f);
         irq_wake = 1'b1;
         wait_on(0, 1'b0, 3, n);
         `CHK(cpu_halt, 1'b0)
         irq_wake = 1'b0;
         rd(PMC_ADDR, f);
      end
      for (int k = 0; k < 6; k++) cause(k, 8'hc0);
      rd(PMC_ADDR, 8'h00);
      wr(SMC_ADDR, 8'h00);
      cause(3, 8'h40);
      // selecting the disabled monitor trips a supply reset at once
      wr(RCR_ADDR, 8'h02);
      `CHK(rst_pin_oe, 1'b1)
      wait_on(2, 1'b1, 6, n);
      `CHK(reset_exit, 1'b1)
      rd(RCR_ADDR, 8'h02);
      rd(SMC_ADDR, 8'h40);
      wr(RCR_ADDR, 8'h01);
      wait_on(1, 1'b1, 4, n);
      `CHK(rst_pin_oe, 1'b1)
      wait_on(2, 1'b1, POR_SIM + 10, n);
      `CHK(reset_exit, 1'b1)
      rd(RCR_ADDR, 8'h02);
      rd(SMC_ADDR, 8'hc0);
      for (int i = 0; i < 2; i++) begin
         bus_power_polarity = !i[0];
         vbus_level = i[0];
         osc_suspend_req = 1'b1;
         @(negedge clock);
         osc_suspend_req = 1'b0;
         repeat (3) @(negedge clock);
         `CHK(osc_stop, 1'b1)
         if (i == 0) usb_nonidle_event = 1'b1;
         else vbus_level = 1'b0;
         wait_on(3, 1'b0, 3, n);
         `CHK(osc_stop, 1'b0)
         usb_nonidle_event = 1'b0;
      end
      repeat (3) @(negedge clock);
      finish_test();
   end
endmodule
